/* core/host_serial_port_mode_select.sv */
// host serial port front end: i2c or spi target, status alert, reset
//
// Summary of operation
// - select high means i2c, low means spi
// - 3-wire spi: data pin is bidirectional
// - 4-wire spi: data pin is input only
// - 4-wire spi: read data on address-one pin
// - i2c: address-one pin sets target address bit
// - i2c: address-zero pin sets target address bit
// - spi: active-low select frames, high ignores bus
// - alert goes low on any status change
// - reset pin restores registers and i2c engine; the spi shifter clears only on select high
// - clock outputs disabled while reset held
`timescale 1ns/10ps
`default_nettype none
module host_serial_port_mode_select (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SERIAL_CLK,
  input wire logic IF_SELECT,
  input wire logic ADDR_BIT_ZERO_OR_SELECT_PIN,
  input wire logic ADDR_BIT_ONE_OR_DATA_OUT_PIN_IN,
  output logic ADDR_BIT_ONE_OR_DATA_OUT_PIN_OUT,
  output logic ADDR_BIT_ONE_OR_DATA_OUT_PIN_OE_N,
  input wire logic DATA_PIN_IN,
  output logic DATA_PIN_OUT,
  output logic DATA_PIN_OE_N,
  input wire logic [7:0] STATUS_IN,
  input wire logic DEVICE_RESET_N,
  output logic STATUS_CHANGE_ALERT_N,
  output logic CLOCK_OUT_ENABLE
);
  import hostport_pkg::*;

  logic [PIN_COUNT-1:0] pins_raw, s1_r, s2_r, s3_r, pin_q_r, pin_q_nxt;
  logic scl_d_r, sda_d_r, wdone_d_r;
  logic int_rst, i2c_mode, scl, sda, scl_rise, scl_fall, start, stop;
  logic spi_sdio_out, spi_sdio_oe_n, spi_sdo_out, spi_sdo_oe_n, spi_done;
  reg_write_t spi_wr;
  reg_bank_t bank;
  i2c_state_t ist_r, ist_nxt, itgt_r, itgt_nxt;
  logic [3:0] icnt_r, icnt_nxt;
  logic [7:0] ish_r, ish_nxt, iptr_r, iptr_nxt;
  logic ilow_r, ilow_nxt;
  logic i2c_wr_req, spi_wr_evt, wr_any;
  reg_write_t i2c_wr, wr_sel;
  logic [7:0] status_r, status_nxt, flags_r, flags_nxt, ctrl_r, ctrl_nxt;
  logic [7:0] clr;
  logic alert_n_r, alert_n_nxt, clk_en_r, clk_en_nxt;

  // the serial clock pin is both the spi link clock and a sampled i2c line
  assign pins_raw = {spi_done, DEVICE_RESET_N, SERIAL_CLK, DATA_PIN_IN,
                     ADDR_BIT_ONE_OR_DATA_OUT_PIN_IN,
                     ADDR_BIT_ZERO_OR_SELECT_PIN, IF_SELECT};

  // level accepted only once the second and third stages agree
  assign pin_q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_q_r);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s1_r <= PINS_RESET;
      s2_r <= PINS_RESET;
      s3_r <= PINS_RESET;
      pin_q_r <= PINS_RESET;
    end else begin
      s1_r <= pins_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_q_r <= pin_q_nxt;
    end
  end

  assign int_rst = SYS_RST | ~pin_q_r[PIN_RSTN];
  assign i2c_mode = pin_q_r[PIN_SEL];
  assign scl = pin_q_r[PIN_SCL];
  assign sda = pin_q_r[PIN_SDA];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start = scl & scl_d_r & sda_d_r & ~sda;
  assign stop = scl & scl_d_r & ~sda_d_r & sda;
  assign spi_wr_evt = pin_q_r[PIN_WDONE] & ~wdone_d_r & ~i2c_mode;

  assign bank.status = status_r;
  assign bank.flags = flags_r;
  assign bank.ctrl = ctrl_r;

  spi_link_engine u_spi (
    .sclk(SERIAL_CLK),
    .cs_n(ADDR_BIT_ZERO_OR_SELECT_PIN),
    .sdi(DATA_PIN_IN),
    .three_wire(ctrl_r[CTRL_3WIRE_BIT]),
    .bank(bank),
    .sdio_out(spi_sdio_out),
    .sdio_oe_n(spi_sdio_oe_n),
    .sdo_out(spi_sdo_out),
    .sdo_oe_n(spi_sdo_oe_n),
    .wr_done(spi_done),
    .wr(spi_wr)
  );

  // i2c target, oversampled on the system clock
  always_comb begin
    ist_nxt = ist_r;
    itgt_nxt = itgt_r;
    icnt_nxt = icnt_r;
    ish_nxt = ish_r;
    iptr_nxt = iptr_r;
    ilow_nxt = ilow_r;
    i2c_wr_req = 1'b0;
    i2c_wr.addr = iptr_r;
    i2c_wr.data = ish_r;
    if (!i2c_mode || stop) begin
      ist_nxt = I_IDLE;
      ilow_nxt = 1'b0;
    end else if (start) begin
      ist_nxt = I_ADDR;
      icnt_nxt = 4'h0;
      ilow_nxt = 1'b0;
    end else begin
      case (ist_r)
        I_ADDR, I_REG, I_WDATA: begin
          if (scl_rise && icnt_r != I2C_BYTE_BITS) begin
            ish_nxt = {ish_r[6:0], sda};
            icnt_nxt = 4'(icnt_r + 4'h1);
          end else if (scl_fall && icnt_r == I2C_BYTE_BITS) begin
            icnt_nxt = 4'h0;
            ist_nxt = I_ACK;
            ilow_nxt = 1'b1;
            itgt_nxt = I_WDATA;
            if (ist_r == I_ADDR) begin
              // low address bits come from the two shared pins
              if (ish_r[7:1] == {I2C_ADDR_BASE, pin_q_r[PIN_A1],
                                 pin_q_r[PIN_CS]}) begin
                itgt_nxt = ish_r[0] ? I_RDATA : I_REG;
              end else begin
                ist_nxt = I_IDLE;
                ilow_nxt = 1'b0;
              end
            end else if (ist_r == I_REG) begin
              iptr_nxt = ish_r;
            end else begin
              i2c_wr_req = 1'b1;
              iptr_nxt = 8'(iptr_r + 8'h01);
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            ist_nxt = itgt_r;
            ilow_nxt = 1'b0;
            if (itgt_r == I_RDATA) begin
              ish_nxt = reg_read(iptr_r, bank);
              ilow_nxt = ~ish_nxt[7];
            end
          end
        end
        I_RDATA: begin
          if (scl_rise) begin
            icnt_nxt = 4'(icnt_r + 4'h1);
          end else if (scl_fall) begin
            if (icnt_r == I2C_BYTE_BITS) begin
              ilow_nxt = 1'b0;
              ist_nxt = I_RACK;
            end else begin
              ish_nxt = {ish_r[6:0], 1'b0};
              ilow_nxt = ~ish_r[6];
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            icnt_nxt = 4'h0;
            if (sda) begin
              ist_nxt = I_IDLE;
            end else begin
              iptr_nxt = 8'(iptr_r + 8'h01);
              ist_nxt = I_ACK;
              itgt_nxt = I_RDATA;
            end
          end
        end
        default: begin
          ist_nxt = I_IDLE;
          ilow_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (int_rst) begin
      ist_r <= I_IDLE;
      itgt_r <= I_IDLE;
      icnt_r <= 4'h0;
      ish_r <= 8'h00;
      iptr_r <= 8'h00;
      ilow_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      wdone_d_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      itgt_r <= itgt_nxt;
      icnt_r <= icnt_nxt;
      ish_r <= ish_nxt;
      iptr_r <= iptr_nxt;
      ilow_r <= ilow_nxt;
      scl_d_r <= scl;
      sda_d_r <= sda;
      wdone_d_r <= pin_q_r[PIN_WDONE];
    end
  end

  // register file shared by both serial modes
  always_comb begin
    wr_any = i2c_wr_req | spi_wr_evt;
    wr_sel = i2c_wr_req ? i2c_wr : spi_wr;
    clr = 8'h00;
    ctrl_nxt = ctrl_r;
    if (wr_any && wr_sel.addr == REG_FLAGS) begin
      clr = wr_sel.data;
    end
    if (wr_any && wr_sel.addr == REG_CTRL) begin
      ctrl_nxt = wr_sel.data;
    end
    status_nxt = STATUS_IN;
    // a change landing with its clear still sets the flag
    flags_nxt = (flags_r & ~clr) | (STATUS_IN ^ status_r);
    alert_n_nxt = ~(|flags_nxt);
    clk_en_nxt = ctrl_nxt[CTRL_OUT_EN_BIT];
  end

  always_ff @(posedge CLOCK) begin
    if (int_rst) begin
      status_r <= STATUS_IN;
      flags_r <= FLAGS_RESET;
      ctrl_r <= CTRL_RESET;
      alert_n_r <= 1'b1;
      clk_en_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      flags_r <= flags_nxt;
      ctrl_r <= ctrl_nxt;
      alert_n_r <= alert_n_nxt;
      clk_en_r <= clk_en_nxt;
    end
  end

  // pin sharing follows the filtered mode select each cycle, so the mux toggles live when it changes
  assign DATA_PIN_OUT = i2c_mode ? 1'b0 : spi_sdio_out;
  assign DATA_PIN_OE_N = i2c_mode ? ~ilow_r : spi_sdio_oe_n;
  assign ADDR_BIT_ONE_OR_DATA_OUT_PIN_OUT = spi_sdo_out;
  assign ADDR_BIT_ONE_OR_DATA_OUT_PIN_OE_N = i2c_mode | spi_sdo_oe_n;
  assign STATUS_CHANGE_ALERT_N = alert_n_r;
  assign CLOCK_OUT_ENABLE = clk_en_r;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_addr_end;
    ist_r == I_ADDR && scl_fall && icnt_r == I2C_BYTE_BITS && i2c_mode
      && !start && !stop && !int_rst;
  endsequence

  sequence s_status_change;
    STATUS_IN != status_r && !int_rst;
  endsequence

  chk_spi_mode_idle: assert property (!i2c_mode |=> ist_r == I_IDLE && !ilow_r)
    else $error("i2c engine active in spi mode");

  chk_addr_pin_input: assert property (i2c_mode |-> ADDR_BIT_ONE_OR_DATA_OUT_PIN_OE_N)
    else $error("address-one pin driven in i2c mode");

  chk_addr_mismatch: assert property (s_addr_end
    ##0 (ish_r[2:1] != {pin_q_r[PIN_A1], pin_q_r[PIN_CS]}) |=> ist_r == I_IDLE)
    else $error("target answered a foreign address");

  chk_select_ignore: assert property (pin_q_r[PIN_CS] [*6] |=> !spi_wr_evt)
    else $error("spi write taken with select high");

  chk_alert_on_change: assert property (s_status_change |=> !STATUS_CHANGE_ALERT_N)
    else $error("status change did not raise alert");

  chk_alert_held: assert property (!STATUS_CHANGE_ALERT_N && !wr_any && !int_rst
    |=> !STATUS_CHANGE_ALERT_N)
    else $error("alert released without a clear");

  chk_alert_release: assert property (!int_rst && flags_nxt == 8'h00
    |=> STATUS_CHANGE_ALERT_N)
    else $error("alert held with no pending flag");

  chk_reset_defaults: assert property (int_rst |=> ctrl_r == CTRL_RESET
    && flags_r == FLAGS_RESET && STATUS_CHANGE_ALERT_N && ist_r == I_IDLE)
    else $error("reset did not restore defaults");

  chk_outputs_off: assert property (int_rst |=> !CLOCK_OUT_ENABLE)
    else $error("clock outputs enabled during reset");
endmodule // host_serial_port_mode_select
`default_nettype wire

/* core/hostport_pkg.sv */
// shared constants, types and register decode for the host serial port
package hostport_pkg;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h01;
  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam int CTRL_3WIRE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // arbitrary upper target address bits; the pins supply the two low bits
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0A;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
  localparam logic [4:0] SPI_LAST_BIT = 5'h0F;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam int PIN_SEL = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_A1 = 2;
  localparam int PIN_SDA = 3;
  localparam int PIN_SCL = 4;
  localparam int PIN_RSTN = 5;
  localparam int PIN_WDONE = 6;
  localparam int PIN_COUNT = 7;
  localparam logic [6:0] PINS_RESET = 7'h3F;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] flags;
    logic [7:0] ctrl;
  } reg_bank_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum {I_IDLE, I_ADDR, I_REG, I_WDATA, I_ACK, I_RDATA, I_RACK}
    i2c_state_t;

  function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                          input reg_bank_t bank);
    case (addr)
      REG_STATUS: reg_read = bank.status;
      REG_FLAGS: reg_read = bank.flags;
      REG_CTRL: reg_read = bank.ctrl;
      default: reg_read = 8'h00;
    endcase
  endfunction
endpackage

/* core/spi_link_engine.sv */
// spi target shifter running on the host serial clock
`timescale 1ns/10ps
`default_nettype none
module spi_link_engine (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic three_wire,
  input wire hostport_pkg::reg_bank_t bank,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic wr_done,
  output hostport_pkg::reg_write_t wr
);
  import hostport_pkg::*;

  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic done_r, done_nxt;
  reg_write_t wr_r, wr_nxt;
  logic drv_r, drv_nxt;
  logic bit_r, bit_nxt;
  logic [7:0] rd_byte;

  // bank is only sampled inside a frame, when the system side holds it
  assign rd_byte = reg_read({1'b0, cmd_r[6:0]}, bank);

  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = {sh_r[6:0], sdi};
    cmd_nxt = cmd_r;
    done_nxt = done_r;
    wr_nxt = wr_r;
    if (cnt_r != SPI_FRAME_BITS) begin
      cnt_nxt = 5'(cnt_r + 5'h01);
    end
    if (cnt_r == SPI_CMD_LAST) begin
      cmd_nxt = {sh_r[6:0], sdi};
    end
    if (cnt_r == SPI_LAST_BIT && !cmd_r[7]) begin
      wr_nxt.addr = {1'b0, cmd_r[6:0]};
      wr_nxt.data = {sh_r[6:0], sdi};
      done_nxt = 1'b1;
    end
  end

  // frame end (select high) clears the frame state at once
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= 5'h00;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      done_r <= done_nxt;
    end
  end

  // held past frame end so the system side can still pick it up
  always_ff @(posedge sclk) begin
    wr_r <= wr_nxt;
  end

  always_comb begin
    drv_nxt = 1'b0;
    bit_nxt = 1'b0;
    if (cmd_r[7] && cnt_r >= SPI_DATA_FIRST && cnt_r != SPI_FRAME_BITS) begin
      drv_nxt = 1'b1;
      bit_nxt = rd_byte[3'(SPI_LAST_BIT - cnt_r)];
    end
  end

  // read data launched on the falling edge, host samples on rising
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      drv_r <= 1'b0;
      bit_r <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
      bit_r <= bit_nxt;
    end
  end

  assign sdio_out = bit_r;
  assign sdio_oe_n = ~(drv_r & three_wire);
  assign sdo_out = bit_r;
  assign sdo_oe_n = ~(drv_r & ~three_wire);
  assign wr_done = done_r;
  assign wr = wr_r;

  chk_3wire_read_drive: assert property (@(posedge sclk) disable iff (cs_n)
    (three_wire && cmd_r[7] && cnt_r inside {[8:15]})
      |-> (!sdio_oe_n && sdo_oe_n))
    else $error("3-wire read data not on the data pin");

  chk_4wire_sdio_off: assert property (@(posedge sclk) disable iff (cs_n)
    !three_wire |-> sdio_oe_n)
    else $error("data pin driven in 4-wire mode");

  chk_4wire_sdo_data: assert property (@(posedge sclk) disable iff (cs_n)
    (!three_wire && cmd_r[7] && cnt_r inside {[8:15]})
      |-> (!sdo_oe_n && sdo_out == rd_byte[3'(SPI_LAST_BIT - cnt_r)]))
    else $error("4-wire read data wrong on data output");
endmodule // spi_link_engine
`default_nettype wire

/* tb/host_model.sv */
// host controller model: spi and i2c master on the serial pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk_fill,
  input wire logic i2c_mode,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic a1_out,
  input wire logic a1_oe_n,
  output logic sclk,
  output logic sel_pin,
  output logic a1_line,
  output logic data_line
);
  logic host_oe = 1'b0;
  logic host_d = 1'b0;
  logic a1_strap = 1'b0;
  logic fill = 1'b0;
  initial begin
    sclk = 1'b0;
    sel_pin = 1'b1;
  end
  // released spi lines have no pull, so they toggle rather than hold
  always @(posedge clk_fill) fill <= ~fill;
  assign data_line = i2c_mode ? ~(~data_oe_n | (host_oe & ~host_d)) :
    ~data_oe_n ? data_out : host_oe ? host_d : fill;
  assign a1_line = ~a1_oe_n ? a1_out : i2c_mode ? a1_strap : fill;

  task automatic set_i2c(input logic a0, input logic a1);
    sclk = 1'b1;
    host_oe = 1'b0;
    sel_pin = a0;
    a1_strap = a1;
  endtask

  task automatic spi_xfer(input logic [7:0] cmd, input logic [7:0] wd,
      input logic three, output logic [7:0] rd, output logic oe_seen);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    oe_seen = 1'b1;
    sel_pin = 1'b0;
    host_oe = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      host_d = sh[i];
      if (i == 7 && cmd[7] && three) host_oe = 1'b0;
      #15 sclk = 1'b1;
      if (i < 8) rd[i] = three ? data_line : a1_line;
      oe_seen = oe_seen & data_oe_n;
      #15 sclk = 1'b0;
    end
    host_oe = 1'b0;
    #200 sel_pin = 1'b1;
    #400;
  endtask

  task automatic i2c_addr(input logic [7:0] byte_v, output logic ack);
    host_oe = 1'b1;
    host_d = 1'b1;
    #500 host_d = 1'b0;
    #500 sclk = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #250 host_d = byte_v[i];
      #250 sclk = 1'b1;
      #500 sclk = 1'b0;
    end
    #250 host_oe = 1'b0;
    #250 sclk = 1'b1;
    ack = ~data_line;
    #500 sclk = 1'b0;
    #250 host_oe = 1'b1;
    host_d = 1'b0;
    #250 sclk = 1'b1;
    #500 host_d = 1'b1;
    #500;
  endtask
endmodule // host_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the host serial port front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hostport_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic if_select = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic device_reset_n = 1'b1;
  logic sclk, sel_pin, a1_line, data_line;
  logic a1_out, a1_oe_n, data_out, data_oe_n, alert_n, clk_en;
  int fail_count = 0;
  int compares = 0;

  always #25 clock = ~clock;

  host_serial_port_mode_select dut (
    .CLOCK(clock),
    .SYS_RST(sys_rst),
    .SERIAL_CLK(sclk),
    .IF_SELECT(if_select),
    .ADDR_BIT_ZERO_OR_SELECT_PIN(sel_pin),
    .ADDR_BIT_ONE_OR_DATA_OUT_PIN_IN(a1_line),
    .ADDR_BIT_ONE_OR_DATA_OUT_PIN_OUT(a1_out),
    .ADDR_BIT_ONE_OR_DATA_OUT_PIN_OE_N(a1_oe_n),
    .DATA_PIN_IN(data_line),
    .DATA_PIN_OUT(data_out),
    .DATA_PIN_OE_N(data_oe_n),
    .STATUS_IN(status_in),
    .DEVICE_RESET_N(device_reset_n),
    .STATUS_CHANGE_ALERT_N(alert_n),
    .CLOCK_OUT_ENABLE(clk_en)
  );

  host_model host (
    .clk_fill(clock),
    .i2c_mode(if_select),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .a1_out(a1_out),
    .a1_oe_n(a1_oe_n),
    .sclk(sclk),
    .sel_pin(sel_pin),
    .a1_line(a1_line),
    .data_line(data_line)
  );

  task automatic check_bit(input string what, input logic exp,
      input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic spi_read(input logic [7:0] addr, input logic three,
      output logic [7:0] rd);
    logic oe;
    host.spi_xfer({1'b1, addr[6:0]}, 8'h00, three, rd, oe);
    if (!three) check_bit("data oe 4-wire", 1'b1, oe);
    cycles(1);
  endtask

  task automatic spi_write(input logic [7:0] addr, input logic [7:0] wd);
    logic [7:0] rd;
    logic oe;
    host.spi_xfer({1'b0, addr[6:0]}, wd, 1'b0, rd, oe);
    cycles(2);
  endtask

  task automatic test_reset();
    cycles(3);
    check_bit("clk enable in reset", 1'b0, clk_en);
    check_bit("alert in reset", 1'b1, alert_n);
    cycles(3);
    sys_rst = 1'b0;
    cycles(1);
    check_bit("clk enable after reset", 1'b1, clk_en);
    cycles(6);
    $display("test reset done");
  endtask

  task automatic test_spi4();
    logic [7:0] rd;
    spi_read(REG_CTRL, 1'b0, rd);
    check_byte("ctrl 4-wire", CTRL_RESET, rd);
    spi_read(8'h7F, 1'b0, rd);
    check_byte("unmapped read", 8'h00, rd);
    $display("test spi4 done");
  endtask

  task automatic test_alert();
    logic [7:0] rd;
    status_in = 8'h5A;
    cycles(1);
    check_bit("alert on change", 1'b0, alert_n);
    cycles(20);
    check_bit("alert held", 1'b0, alert_n);
    spi_read(REG_STATUS, 1'b0, rd);
    check_byte("status", 8'h5A, rd);
    spi_read(REG_FLAGS, 1'b0, rd);
    check_byte("flags", 8'h5A, rd);
    check_bit("alert after read", 1'b0, alert_n);
    spi_write(REG_FLAGS, 8'h5A);
    check_bit("alert cleared", 1'b1, alert_n);
    $display("test alert done");
  endtask

  task automatic test_spi3();
    logic [7:0] wd;
    logic [7:0] rd;
    wd = 8'h00;
    wd[CTRL_3WIRE_BIT] = 1'b1;
    spi_write(REG_CTRL, wd);
    check_bit("clk enable off", 1'b0, clk_en);
    spi_read(REG_CTRL, 1'b1, rd);
    check_byte("ctrl 3-wire", wd, rd);
    $display("test spi3 done");
  endtask

  task automatic test_pin_reset();
    logic [7:0] rd;
    device_reset_n = 1'b0;
    cycles(8);
    check_bit("clk enable in pin reset", 1'b0, clk_en);
    check_bit("alert in pin reset", 1'b1, alert_n);
    device_reset_n = 1'b1;
    cycles(8);
    check_bit("clk enable after pin reset", 1'b1, clk_en);
    spi_read(REG_CTRL, 1'b0, rd);
    check_byte("ctrl default", CTRL_RESET, rd);
    $display("test pin reset done");
  endtask

  task automatic test_i2c();
    logic ack;
    host.set_i2c(1'b1, 1'b0);
    if_select = 1'b1;
    cycles(10);
    host.i2c_addr({I2C_ADDR_BASE, 2'b01, 1'b0}, ack);
    check_bit("ack own address", 1'b1, ack);
    check_bit("a1 oe in i2c", 1'b1, a1_oe_n);
    host.i2c_addr({I2C_ADDR_BASE, 2'b10, 1'b0}, ack);
    check_bit("nack other address", 1'b0, ack);
    host.set_i2c(1'b0, 1'b1);
    cycles(10);
    host.i2c_addr({I2C_ADDR_BASE, 2'b10, 1'b0}, ack);
    check_bit("ack strapped address", 1'b1, ack);
    $display("test i2c done");
  endtask

  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    test_reset();
    test_spi4();
    test_alert();
    test_spi3();
    test_pin_reset();
    test_i2c();
    report_and_stop();
  end

  // whole run is near 47 us; a hang is cut well beyond that
  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
